//--- src/rfp_ahb.sv
// minimal AHB-Lite slave front end: captures the address phase and
// leaves the zero-wait OKAY responses and register storage to the top.
// assumes a single master and whole-word transfers.
module rfp_ahb (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // ahb address phase
   input  wire logic        hsel,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [7:0]  haddr,
   input  wire logic        hready,
   // captured data phase
   output logic             wr_act,
   output logic             rd_act,
   output logic [7:0]       addr
);
   import rfp_pkg::*;

   logic take;

   assign take = hsel && hready && htrans[1];

   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_act <= 1'b0;
         rd_act <= 1'b0;
         addr   <= 8'h00;
      end else if (hready) begin
         wr_act <= take && hwrite;
         rd_act <= take && !hwrite;
         if (take) begin
            addr <= haddr;
         end
      end
   end

endmodule : rfp_ahb

//--- src/rfp_lane.sv
// packs one character and its status into a 16-bit lane.
// assumes inputs come from same-clock decoder logic.
module rfp_lane (
   // character in
   input  wire rfp_pkg::rfp_char_t ch,
   // mode
   input  wire logic               raw_mode,
   input  wire logic               enc_on,
   input  wire logic               pipe_on,
   // lane out
   output logic [15:0]             lane
);
   import rfp_pkg::*;

   always_comb begin
      lane = 16'h0000;
      if (raw_mode) begin
         lane[RFP_RAW_W-1:0] = ch.raw;
         lane[RFP_B_DERR]    = ch.st.disp_err;
      end else begin
         lane[RFP_DATA_W-1:0] = ch.data;
         if (enc_on) begin
            lane[RFP_B_CTRL] = ch.st.ctrl;
            lane[RFP_B_CERR] = ch.st.code_err;
            lane[RFP_B_DERR] = ch.st.disp_err;
         end
      end
      if (raw_mode || enc_on) begin
         lane[RFP_B_SYNC]  = ch.st.sync;
         lane[RFP_B_PAT]   = ch.st.pat_det;
         lane[RFP_B_RDISP] = ch.st.run_disp;
         if (pipe_on) begin
            lane[RFP_B_RMINS:RFP_B_RMDEL] = ch.st.pipe_st;
         end else begin
            lane[RFP_B_RMDEL] = ch.st.rm_del;
            lane[RFP_B_RMINS] = ch.st.rm_ins;
         end
      end
   end

endmodule : rfp_lane

//--- src/rfp_pkg.sv
// package for the receive fabric word packer: bit positions, modes,
// register map and the status carrier shared by all design files.
// assumes a single 100 MHz clock and an AHB-Lite register slave.
package rfp_pkg;

   // fabric interface width selection
   typedef enum logic [1:0] {
      RFP_W8  = 2'h0,
      RFP_W10 = 2'h1,
      RFP_W16 = 2'h2
   } rfp_width_t;

   // per-character status from the decoder and word aligner
   typedef struct packed {
      logic       ctrl;
      logic       code_err;
      logic       sync;
      logic       disp_err;
      logic       pat_det;
      logic       rm_del;
      logic       rm_ins;
      logic [1:0] pipe_st;
      logic       run_disp;
   } rfp_stat_t;

   // one received character: raw 10-bit group, decoded byte, status
   typedef struct packed {
      logic [9:0] raw;
      logic [7:0] data;
      rfp_stat_t  st;
   } rfp_char_t;

   // receive word layout, per byte lane
   localparam int RFP_LANE_W    = 16;
   localparam int RFP_DATA_LO   = 0;
   localparam int RFP_DATA_W    = 8;
   localparam int RFP_RAW_W     = 10;
   localparam int RFP_B_CTRL    = 8;
   localparam int RFP_B_CERR    = 9;
   localparam int RFP_B_SYNC    = 10;
   localparam int RFP_B_DERR    = 11;
   localparam int RFP_B_PAT     = 12;
   localparam int RFP_B_RMDEL   = 13;
   localparam int RFP_B_RMINS   = 14;
   localparam int RFP_B_RDISP   = 15;

   // register map (byte addresses)
   localparam logic [7:0] RFP_A_CTRL   = 8'h00;
   localparam logic [7:0] RFP_A_STATUS = 8'h04;
   localparam logic [7:0] RFP_A_WORD   = 8'h08;
   localparam logic [7:0] RFP_A_COUNT  = 8'h0c;

   // control register fields and reset value
   localparam int RFP_C_WIDTH_LO = 0;
   localparam int RFP_C_ENC      = 2;
   localparam int RFP_C_PIPE     = 3;
   localparam int RFP_C_EN       = 4;
   localparam logic [4:0] RFP_CTRL_RST = 5'h14;

endpackage : rfp_pkg

//--- src/rfp_top.sv
// receive fabric word packer: builds the 32-bit receive word from one
// or two decoded characters per cycle, with an AHB-Lite control slave.
// assumes decoder, aligner and rate-match logic run on mclk.
//
// Function
// - 8-bit encoded: decoded byte on bits 7:0
// - 8-bit status bits only in 8B/10B mode
// - bit 8 is control-character flag
// - bit 9 is code-violation flag
// - bit 11 is disparity-error flag
// - bit 12 is pattern-detect flag
// - bit 13 rate-match delete outside PIPE
// - bit 14 rate-match insert outside PIPE
// - PIPE mode: bits 14:13 carry PIPE status
// - bit 15 is running disparity
// - 10-bit mode: raw group on bits 9:0
// - 10-bit mode: bit 11 disparity error
// - 16-bit: low byte 7:0, high 23:16
// - 16-bit status only in 16-bit 8B/10B
// - control flags on bits 8 and 24
// - code-violation flags on bits 9 and 25
// - sync flags on bits 10 and 26
// - disparity-error flags on bits 11 and 27
// - pattern-detect flags on bits 12 and 28
// - running disparity on bits 15 and 31
module rfp_top #(
   parameter int LANES = 2
) (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                srst,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [7:0]          haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   // characters from the receive path, lane 0 is the low byte
   input  wire rfp_pkg::rfp_char_t  rx_char [LANES],
   input  wire logic                rx_valid,
   // receive word to fabric
   output logic [31:0]              rx_word,
   output logic                     rx_word_valid
);
   import rfp_pkg::*;

   logic [4:0]  ctrl_reg;
   logic [31:0] word_next;
   logic [31:0] count_reg;
   logic        wr_act;
   logic        rd_act;
   logic [7:0]  addr;
   logic [15:0] lane_w [LANES];
   rfp_width_t  width;
   logic        raw_mode;
   logic        enc_on;
   logic        pipe_on;
   logic        enable;

   assign width    = rfp_width_t'(ctrl_reg[RFP_C_WIDTH_LO +: 2]);
   assign raw_mode = (width == RFP_W10);
   assign enc_on   = ctrl_reg[RFP_C_ENC];
   assign pipe_on  = ctrl_reg[RFP_C_PIPE];
   assign enable   = ctrl_reg[RFP_C_EN];

   rfp_ahb u_ahb (
      .mclk   (mclk),
      .srst   (srst),
      .hsel   (hsel),
      .htrans (htrans),
      .hwrite (hwrite),
      .haddr  (haddr),
      .hready (hready),
      .wr_act (wr_act),
      .rd_act (rd_act),
      .addr   (addr)
   );

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // one packer per byte lane
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      rfp_lane u_lane (
         .ch       (rx_char[i]),
         .raw_mode (raw_mode),
         .enc_on   (enc_on),
         .pipe_on  (pipe_on),
         .lane     (lane_w[i])
      );
   end

   // assemble the word; upper lane used only in 16-bit mode
   always_comb begin
      word_next = 32'h0000_0000;
      word_next[RFP_LANE_W-1:0] = lane_w[0];
      if (width == RFP_W16 && LANES > 1) begin
         word_next[2*RFP_LANE_W-1:RFP_LANE_W] = lane_w[LANES-1];
      end
   end

   // data and its status leave in the same cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_word       <= 32'h0000_0000;
         rx_word_valid <= 1'b0;
      end else begin
         rx_word_valid <= rx_valid && enable;
         if (rx_valid && enable) begin
            rx_word <= word_next;
         end
      end
   end

   // control register
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_reg <= RFP_CTRL_RST;
      end else if (wr_act && addr == RFP_A_CTRL) begin
         ctrl_reg <= hwdata[4:0];
      end
   end

   // word counter, cleared by any write to it
   always_ff @(posedge mclk) begin
      if (srst) begin
         count_reg <= 32'h0000_0000;
      end else if (wr_act && addr == RFP_A_COUNT) begin
         count_reg <= 32'h0000_0000;
      end else if (rx_valid && enable) begin
         count_reg <= count_reg + 32'h0000_0001;
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_act) begin
         unique case (addr)
            RFP_A_CTRL:   hrdata = {27'h0, ctrl_reg};
            RFP_A_STATUS: hrdata = {31'h0, rx_word_valid};
            RFP_A_WORD:   hrdata = rx_word;
            RFP_A_COUNT:  hrdata = count_reg;
            default:      hrdata = 32'h0000_0000;
         endcase
      end
   end

endmodule : rfp_top

//--- testbench/rfp_fabric_sink.sv
// fabric consumer model: takes each word with its status bits.
// assumes rx_word_valid is a one-cycle pulse per word.
module rfp_fabric_sink (
   // clock
   input  wire logic        mclk,
   // receive word
   input  wire logic [31:0] rx_word,
   input  wire logic        rx_word_valid,
   // captured word
   output logic             got,
   output logic [31:0]      word
);
   timeunit 1ns;
   timeprecision 1ps;
   // data and status sampled together in the same cycle
   always_ff @(posedge mclk) begin
      got <= rx_word_valid;
      if (rx_word_valid) word <= rx_word;
   end
endmodule : rfp_fabric_sink

//--- testbench/rfp_top_asserts.sv
// checker for the receive word packer, bound to rfp_top.
// assumes control writes at offset 0 are the only mode changes.
module rfp_top_asserts
   import rfp_pkg::*;
#(
   parameter int LANES = 2
) (
   // clock and reset
   input wire logic               mclk,
   input wire logic               srst,
   // ahb-lite slave
   input wire logic               hsel,
   input wire logic [7:0]         haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic [31:0]        hwdata,
   input wire logic               hready,
   // stream
   input wire rfp_pkg::rfp_char_t rx_char [LANES],
   input wire logic               rx_valid,
   input wire logic [31:0]        rx_word,
   input wire logic               rx_word_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr_reg;
   logic [4:0] ctl_reg;
   logic [4:0] pm_reg;
   rfp_char_t  c0_reg;
   rfp_char_t  c1_reg;
   logic       ten;
   logic       st_on;
   logic [1:0] rp;
   assign ten = pm_reg[1:0] == 2'h1;
   assign st_on = ten || pm_reg[RFP_C_ENC];
   assign rp = pm_reg[RFP_C_PIPE] ? c0_reg.st.pipe_st
                                  : {c0_reg.st.rm_ins, c0_reg.st.rm_del};
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // mirror of the mode register
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_reg  <= 1'b0;
         ctl_reg <= RFP_CTRL_RST;
      end else if (hready) begin
         wr_reg <= hsel && htrans[1] && hwrite && haddr == RFP_A_CTRL;
         if (wr_reg) ctl_reg <= hwdata[4:0];
      end
   end
   always_ff @(posedge mclk) begin
      pm_reg <= ctl_reg;
      c0_reg <= rx_char[0];
      c1_reg <= rx_char[1];
   end
   chk_word_go: assert property (
      rx_valid && ctl_reg[RFP_C_EN] |=> rx_word_valid)
      else $error("accepted character gave no word");
   chk_word_stop: assert property (
      !(rx_valid && ctl_reg[RFP_C_EN]) |=> !rx_word_valid)
      else $error("word without accepted character");
   chk_data_lo: assert property (
      rx_word_valid && !ten |-> rx_word[7:0] == c0_reg.data)
      else $error("low data byte wrong");
   chk_raw_ten: assert property (
      rx_word_valid && ten |-> rx_word[9:0] == c0_reg.raw)
      else $error("raw group wrong");
   chk_flags_enc: assert property (
      rx_word_valid && !ten && st_on |-> rx_word[10:8] ==
      {c0_reg.st.sync, c0_reg.st.code_err, c0_reg.st.ctrl})
      else $error("control or violation flag wrong");
   chk_status_mid: assert property (
      rx_word_valid && st_on |-> {rx_word[15], rx_word[12:10]} ==
      {c0_reg.st.run_disp, c0_reg.st.pat_det, c0_reg.st.disp_err,
       c0_reg.st.sync})
      else $error("status bits wrong");
   chk_rate_pipe: assert property (
      rx_word_valid && st_on |-> rx_word[14:13] == rp)
      else $error("rate match or pipe status wrong");
   chk_hi_lane: assert property (
      rx_word_valid && pm_reg[1:0] == 2'h2 && pm_reg[RFP_C_ENC]
      |-> {rx_word[31], rx_word[28:16]} == {c1_reg.st.run_disp,
      c1_reg.st.pat_det, c1_reg.st.disp_err, c1_reg.st.sync,
      c1_reg.st.code_err, c1_reg.st.ctrl, c1_reg.data})
      else $error("high lane wrong");
   chk_plain_data: assert property (
      rx_word_valid && !st_on |-> rx_word[15:8] == 8'h00)
      else $error("status present without decoding");
endmodule : rfp_top_asserts

bind rfp_top rfp_top_asserts #(.LANES(LANES)) u_rfp_top_asserts (
   .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .rx_char(rx_char), .rx_valid(rx_valid), .rx_word(rx_word),
   .rx_word_valid(rx_word_valid));

//--- testbench/tb_rfp_top.sv
// self-checking bench for the receive word packer.
// assumes rfp_top with two lanes and the fabric sink beside it.
module tb_rfp_top;
   import rfp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, srst, hsel, hwrite, hreadyout, hresp;
   logic        rx_valid, rx_word_valid, got;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rx_word, got_word, rd, last;
   rfp_char_t   rx_char [2];
   logic [31:0] q [$];
   int          bad_count, compares, n;
   logic [4:0]  modes [9] = '{5'h14, 5'h1c, 5'h10,
      5'h11, 5'h19,
      5'h16, 5'h1e, 5'h12, 5'h06};
   rfp_top #(.LANES(2)) u_rfp_top (.mclk(mclk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_char(rx_char), .rx_valid(rx_valid), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid));
   rfp_fabric_sink u_rfp_fabric_sink (.mclk(mclk), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid), .got(got), .word(got_word));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic print_verdict;
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   function automatic logic [15:0] lane(rfp_char_t c, logic [4:0] m);
      logic [15:0] l;
      l = 16'h0;
      if (m[1:0] == 2'h1) l[9:0] = c.raw;
      else l[7:0] = c.data;
      if (m[1:0] == 2'h1 || m[2]) begin
         l[15:10] = {c.st.run_disp, m[3] ? c.st.pipe_st :
            {c.st.rm_ins, c.st.rm_del}, c.st.pat_det, c.st.disp_err,
            c.st.sync};
         if (m[1:0] != 2'h1) l[9:8] = {c.st.code_err, c.st.ctrl};
      end
      return l;
   endfunction : lane
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : bus
   task automatic stream(input logic [4:0] m);
      rfp_char_t c0, c1;
      logic      v;
      for (int k = 0; k < 20; k++) begin
         c0 = rfp_char_t'(28'($urandom));
         c1 = rfp_char_t'(28'($urandom));
         v = ($urandom % 4) != 0;
         rx_char[0] <= c0;
         rx_char[1] <= c1;
         rx_valid <= v;
         if (v && m[4]) begin
            last = m[1:0] == 2'h2 ? {lane(c1, m), lane(c0, m)}
                                  : {16'h0, lane(c0, m)};
            q.push_back(last);
            n++;
         end
         @(posedge mclk);
      end
      rx_valid <= 1'b0;
   endtask : stream
   always @(negedge mclk) begin
      if (got === 1'b1)
         check(got_word, q.size() ? q.pop_front() : ~got_word);
   end
   initial begin
      #100us;
      bad_count++;
      print_verdict();
   end
   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rx_valid = 1'b0;
      rx_char = '{default: '0};
      void'($urandom(32'hd524a6a3));
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      bus(1'b0, RFP_A_CTRL, 32'h0, rd);
      check(rd, 32'(RFP_CTRL_RST));
      bus(1'b0, 8'h10, 32'h0, rd);
      check(rd, 32'h0);
      foreach (modes[i]) begin
         bus(1'b1, RFP_A_CTRL, 32'(modes[i]), rd);
         bus(1'b1, RFP_A_COUNT, 32'h0, rd);
         n = 0;
         stream(modes[i]);
         bus(1'b0, RFP_A_COUNT, 32'h0, rd);
         check(rd, 32'(n));
         bus(1'b0, RFP_A_STATUS, 32'h0, rd);
         check(rd, 32'h0);
         if (n > 0) begin
            bus(1'b0, RFP_A_WORD, 32'h0, rd);
            check(rd, last);
         end
      end
      repeat (4) @(posedge mclk);
      check(32'(q.size()), 32'h0);
      print_verdict();
   end
endmodule : tb_rfp_top
